// [rtl/bcd_host.sv]
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bcd_defs.svh"
// What this block does
// - every frame starts with exactly four header bytes, data follows at once
// - first header byte is the command code, 81 to ee, msb set, reserved codes refused
// - second byte is field width code: 00 none, 01, 02 or 04 bytes
// - width code 06 means four integer bytes then two fraction bytes
// - third byte is 01 for coordinated move, 00 otherwise
// - fourth byte is an axis bitmap, bit 0 first axis to bit 7 eighth
// - one field per set bitmap bit, ascending order, none for clear bits
// - multi-byte fields go most significant byte first, two's complement
// - a command without data is just the four header bytes, width 00 or bitmap 00
// - an operand form is marked by a leading underscore
// - text commands end with a semicolon or a carriage return
module bcd_host
   import bcd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic [7:0] link_tx_data,
   output logic link_tx_req,
   input wire logic link_tx_ack,
   input wire logic [7:0] link_rx_data,
   input wire logic link_rx_req,
   output logic link_rx_ack
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic bcd_reserved(input logic [7:0] c);
      logic r;
      r = (c == 8'h80) || (c >= 8'h9b && c <= 8'h9f) || (c >= 8'hab && c <= 8'haf) ||
          (c == 8'hbb) || (c == 8'hbc) || (c == 8'hc7) || (c >= 8'hd5 && c <= 8'hd7) ||
          (c >= 8'he2 && c <= 8'he4) || (c >= 8'hef);
      return r;
   endfunction

   function automatic logic [3:0] bcd_next_field(input logic [7:0] map, input logic [3:0] from);
      logic [3:0] r;
      r = `BCD_NO_FIELD;
      for (int i = 7; i >= 0; i--) begin
         if (4'(i) >= from && map[i]) r = 4'(i);
      end
      return r;
   endfunction

   function automatic logic [3:0] bcd_ones(input logic [7:0] map);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) n = n + {3'b000, map[i]};
      return n;
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   bcd_state_t state_ff;
   logic [31:0] hdr_ff;
   logic [47:0] field_ff [8];
   logic [31:0] val_ff [8];
   logic [7:0] ap_addr_ff;
   logic ap_wr_ff, rd_stage_ff;
   logic [31:0] hrdata_ff;
   logic tx_ack_s, rx_req_s;
   logic [7:0] rx_data_s;
   logic tx_req_ff, rx_ack_ff;
   logic [7:0] tx_data_ff, last_ff, err_ff;
   logic in_hdr_ff;
   logic [1:0] hidx_ff;
   logic [3:0] sel_ff;
   logic [2:0] bidx_ff;
   logic [5:0] sent_ff;
   logic done_ff, ack_ff, nak_ff, lrej_ff, oper_ff, line_ff;
   logic [31:0] acc_ff;
   logic neg_ff, frac_ff, dig_ff;
   logic [3:0] slot_ff;
   logic [7:0] cmd, width, coord, bitmap;
   logic [2:0] wlen;
   logic [5:0] exp_len, sh;
   logic take, wr_go, tx_raise, tx_step, last_byte, rx_take, in_wait;
   logic hdr_ok, code_ok;
   logic [7:0] cur_byte, hdr_byte, data_byte;
   logic [3:0] nxt_sel;
   logic [31:0] rd_mux, nxt_acc;

   assign cmd = hdr_ff[7:0];
   assign width = hdr_ff[15:8];
   assign coord = hdr_ff[23:16];
   assign bitmap = hdr_ff[31:24];
   assign wlen = width[2:0];

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   bcd_sync #(.W(1)) u_sync_ack (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(link_tx_ack),
      .q(tx_ack_s)
   );

   // data rides with req; the device holds it while req is high
   bcd_sync #(.W(9)) u_sync_rx (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({link_rx_req, link_rx_data}),
      .q({rx_req_s, rx_data_s})
   );

   // ----------------------------------------
   // ahb-lite slave
   // ----------------------------------------
   // reads take one wait state so a write just before is always seen
   assign take = hsel && hready && htrans[1];
   assign hreadyout = ~rd_stage_ff;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign wr_go = ap_wr_ff && ap_addr_ff == `BCD_OFF_CTRL && hwdata[`BCD_CTRL_GO];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_addr_ff <= 8'h00;
         ap_wr_ff <= 1'b0;
         rd_stage_ff <= 1'b0;
      end else begin
         ap_wr_ff <= take && hwrite;
         rd_stage_ff <= take && !hwrite;
         if (take) ap_addr_ff <= {haddr[7:2], 2'b00};
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (ap_addr_ff == `BCD_OFF_HDR) begin
         rd_mux = hdr_ff;
      end else if (ap_addr_ff == `BCD_OFF_STAT) begin
         rd_mux[`BCD_STAT_BUSY] = state_ff != BCD_IDLE;
         rd_mux[`BCD_STAT_DONE] = done_ff;
         rd_mux[`BCD_STAT_ACK] = ack_ff;
         rd_mux[`BCD_STAT_NAK] = nak_ff;
         rd_mux[`BCD_STAT_LREJ] = lrej_ff;
         rd_mux[`BCD_STAT_OPER] = oper_ff;
         rd_mux[`BCD_STAT_LINE] = line_ff;
         rd_mux[`BCD_STAT_ERR_LSB +: 8] = err_ff;
         rd_mux[`BCD_STAT_CNT_LSB +: 4] = slot_ff;
      end else if (ap_addr_ff == `BCD_OFF_LAST) begin
         rd_mux[7:0] = last_ff;
      end else if (ap_addr_ff >= `BCD_OFF_FIELD && ap_addr_ff <= `BCD_OFF_FIELD_END) begin
         rd_mux = ap_addr_ff[2] ? {16'h0000, field_ff[ap_addr_ff[5:3]][47:32]}
                                : field_ff[ap_addr_ff[5:3]][31:0];
      end else if (ap_addr_ff >= `BCD_OFF_VAL && ap_addr_ff <= `BCD_OFF_VAL_END) begin
         rd_mux = val_ff[ap_addr_ff[4:2]];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata_ff <= 32'h0000_0000;
      else if (rd_stage_ff) hrdata_ff <= rd_mux;
   end

   // header and fields are frozen while a frame is in flight
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hdr_ff <= `BCD_HDR_RST;
      else if (ap_wr_ff && ap_addr_ff == `BCD_OFF_HDR && state_ff == BCD_IDLE) hdr_ff <= hwdata;
   end

   for (genvar g = 0; g < 8; g++) begin : g_field
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            field_ff[g] <= `BCD_FIELD_RST;
         end else if (ap_wr_ff && state_ff == BCD_IDLE) begin
            if (ap_addr_ff == `BCD_OFF_FIELD + 8'(8 * g)) field_ff[g][31:0] <= hwdata;
            if (ap_addr_ff == `BCD_OFF_FIELD + 8'(8 * g + 4)) field_ff[g][47:32] <= hwdata[15:0];
         end
      end
   end

   // ----------------------------------------
   // frame byte selection
   // ----------------------------------------
   assign exp_len = `BCD_HDR_LEN + ({2'b00, bcd_ones(bitmap)} * {3'b000, wlen});
   assign sh = 6'(({3'b000, wlen} - 6'h01 - {3'b000, bidx_ff}) << 3);
   // for code 06 the top four bytes are integer, the low two fraction
   assign data_byte = 8'(field_ff[sel_ff[2:0]] >> sh);

   always_comb begin
      case (hidx_ff)
         2'h0: hdr_byte = cmd;
         2'h1: hdr_byte = width;
         2'h2: hdr_byte = coord;
         default: hdr_byte = bitmap;
      endcase
   end

   assign cur_byte = in_hdr_ff ? hdr_byte : data_byte;
   assign code_ok = cmd >= `BCD_CMD_MIN && !bcd_reserved(cmd);
   assign hdr_ok = (width == `BCD_W_NONE || width == `BCD_W_1 || width == `BCD_W_2 ||
                    width == `BCD_W_4 || width == `BCD_W_6) &&
                   (coord == `BCD_COORD_OFF || coord == `BCD_COORD_ON);
   assign nxt_sel = bcd_next_field(bitmap, sel_ff + 4'h1);
   assign last_byte = in_hdr_ff ? (hidx_ff == 2'h3 && (width == `BCD_W_NONE || bitmap == 8'h00))
                                : (bidx_ff == wlen - 3'h1 && nxt_sel == `BCD_NO_FIELD);

   // ----------------------------------------
   // link transmit, four-phase req/ack
   // ----------------------------------------
   assign tx_raise = state_ff == BCD_SEND && !tx_req_ff && !tx_ack_s;
   assign tx_step = tx_req_ff && tx_ack_s;
   assign link_tx_req = tx_req_ff;
   assign link_tx_data = tx_data_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_req_ff <= 1'b0;
         tx_data_ff <= 8'h00;
      end else if (tx_raise) begin
         tx_req_ff <= 1'b1;
         tx_data_ff <= cur_byte;
      end else if (tx_step) begin
         tx_req_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   assign in_wait = state_ff == BCD_WAIT;
   assign rx_take = rx_req_s && !rx_ack_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= BCD_IDLE;
         in_hdr_ff <= 1'b1;
         hidx_ff <= 2'h0;
         sel_ff <= 4'h0;
         bidx_ff <= 3'h0;
         sent_ff <= 6'h00;
      end else begin
         case (state_ff)
            BCD_IDLE: begin
               if (wr_go) state_ff <= BCD_CHECK;
            end
            BCD_CHECK: begin
               in_hdr_ff <= 1'b1;
               hidx_ff <= 2'h0;
               sent_ff <= 6'h00;
               state_ff <= (code_ok && hdr_ok) ? BCD_SEND : BCD_IDLE;
            end
            BCD_SEND: begin
               if (tx_step) begin
                  sent_ff <= sent_ff + 6'h01;
                  if (last_byte) begin
                     state_ff <= BCD_WAIT;
                  end else if (in_hdr_ff && hidx_ff != 2'h3) begin
                     hidx_ff <= hidx_ff + 2'h1;
                  end else if (in_hdr_ff || bidx_ff == wlen - 3'h1) begin
                     in_hdr_ff <= 1'b0;
                     sel_ff <= in_hdr_ff ? bcd_next_field(bitmap, 4'h0) : nxt_sel;
                     bidx_ff <= 3'h0;
                  end else begin
                     bidx_ff <= bidx_ff + 3'h1;
                  end
               end
            end
            BCD_WAIT: begin
               if (rx_take && (rx_data_s == `BCD_CH_ACK || rx_data_s == `BCD_CH_NAK)) begin
                  state_ff <= BCD_IDLE;
               end
            end
            default: state_ff <= BCD_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // outcome flags, cleared by the next start
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_ff <= 1'b0;
         ack_ff <= 1'b0;
         nak_ff <= 1'b0;
         lrej_ff <= 1'b0;
         err_ff <= `BCD_ERR_NONE;
      end else if (state_ff == BCD_CHECK && !(code_ok && hdr_ok)) begin
         done_ff <= 1'b1;
         nak_ff <= 1'b1;
         lrej_ff <= 1'b1;
         err_ff <= code_ok ? `BCD_ERR_RANGE : `BCD_ERR_UNRECOG;
      end else if (in_wait && rx_take && rx_data_s == `BCD_CH_ACK) begin
         done_ff <= 1'b1;
         ack_ff <= 1'b1;
      end else if (in_wait && rx_take && rx_data_s == `BCD_CH_NAK) begin
         done_ff <= 1'b1;
         nak_ff <= 1'b1;
      end else if (state_ff == BCD_IDLE && wr_go) begin
         done_ff <= 1'b0;
         ack_ff <= 1'b0;
         nak_ff <= 1'b0;
         lrej_ff <= 1'b0;
         err_ff <= `BCD_ERR_NONE;
      end
   end

   // ----------------------------------------
   // link receive and decimal reply parser
   // ----------------------------------------
   // bytes outside a wait are acked and dropped so the device never hangs
   assign link_rx_ack = rx_ack_ff;
   assign nxt_acc = (acc_ff << 3) + (acc_ff << 1) + {24'h000000, rx_data_s - `BCD_CH_ZERO};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_ack_ff <= 1'b0;
         last_ff <= 8'h00;
      end else if (rx_take) begin
         rx_ack_ff <= 1'b1;
         last_ff <= rx_data_s;
      end else if (!rx_req_s) begin
         rx_ack_ff <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_ff <= 32'h0000_0000;
         neg_ff <= 1'b0;
         frac_ff <= 1'b0;
         dig_ff <= 1'b0;
         slot_ff <= 4'h0;
         oper_ff <= 1'b0;
         line_ff <= 1'b0;
         for (int i = 0; i < 8; i++) val_ff[i] <= 32'h0000_0000;
      end else if (state_ff == BCD_CHECK) begin
         acc_ff <= 32'h0000_0000;
         neg_ff <= 1'b0;
         frac_ff <= 1'b0;
         dig_ff <= 1'b0;
         slot_ff <= 4'h0;
         oper_ff <= 1'b0;
         line_ff <= 1'b0;
      end else if (in_wait && rx_take) begin
         if (rx_data_s >= `BCD_CH_ZERO && rx_data_s <= `BCD_CH_NINE) begin
            dig_ff <= 1'b1;
            if (!frac_ff) acc_ff <= nxt_acc;
         end else if (rx_data_s == `BCD_CH_MINUS) begin
            neg_ff <= 1'b1;
         end else if (rx_data_s == `BCD_CH_DOT) begin
            frac_ff <= 1'b1;
         end else if (rx_data_s == `BCD_CH_UNDER) begin
            oper_ff <= 1'b1;
         end else if (rx_data_s == `BCD_CH_LF) begin
            line_ff <= 1'b1;
         end else if (rx_data_s == `BCD_CH_COMMA || rx_data_s == `BCD_CH_CR ||
                      rx_data_s == `BCD_CH_SEMI) begin
            // one value per axis in axis order, an empty slot advances only when a comma ends it
            if (slot_ff != 4'h8 && (dig_ff || rx_data_s == `BCD_CH_COMMA)) begin
               if (dig_ff) val_ff[slot_ff[2:0]] <= neg_ff ? 32'(-acc_ff) : acc_ff;
               slot_ff <= slot_ff + 4'h1;
            end
            acc_ff <= 32'h0000_0000;
            neg_ff <= 1'b0;
            frac_ff <= 1'b0;
            dig_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_first_is_cmd: assert property (
      $rose(link_tx_req) && sent_ff == 6'h00 |-> link_tx_data == cmd)
      else $error("first frame byte is not the command code");
   a_cmd_msb_set: assert property (
      $rose(link_tx_req) && sent_ff == 6'h00 |-> link_tx_data[7])
      else $error("command code sent without msb set");
   a_width_legal: assert property (
      state_ff == BCD_SEND |-> width inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h06})
      else $error("illegal width code on the link");
   a_fixed_point_order: assert property (
      $rose(link_tx_req) && !in_hdr_ff && width == `BCD_W_6 && bidx_ff == 3'h4
      |-> link_tx_data == field_ff[sel_ff[2:0]][15:8])
      else $error("fraction part not after integer part");
   a_coord_legal: assert property (
      $rose(link_tx_req) && sent_ff == 6'h02 |-> link_tx_data <= `BCD_COORD_ON)
      else $error("coordinated flag not 00 or 01");
   a_only_set_bits: assert property (
      $rose(link_tx_req) && !in_hdr_ff |-> bitmap[sel_ff[2:0]] && sel_ff < 4'h8)
      else $error("field sent for a clear bitmap bit");
   a_msb_first: assert property (
      $rose(link_tx_req) && !in_hdr_ff && width == `BCD_W_2 && bidx_ff == 3'h0
      |-> link_tx_data == field_ff[sel_ff[2:0]][15:8])
      else $error("two byte field not sent high byte first");
   a_exact_length: assert property (
      state_ff == BCD_SEND ##1 state_ff == BCD_WAIT |-> sent_ff == exp_len)
      else $error("frame length differs from width times field count");
   a_empty_frame: assert property (
      state_ff == BCD_SEND && width == `BCD_W_NONE ##1 state_ff == BCD_WAIT
      |-> sent_ff == `BCD_HDR_LEN)
      else $error("no-data frame is not four bytes");
   a_reserved_rejected: assert property (
      state_ff == BCD_CHECK && bcd_reserved(cmd)
      |=> state_ff == BCD_IDLE && lrej_ff && err_ff == `BCD_ERR_UNRECOG && !link_tx_req)
      else $error("reserved code not rejected locally");
   a_reply_closes: assert property (
      in_wait && rx_take && rx_data_s == `BCD_CH_ACK |=> state_ff == BCD_IDLE && done_ff && ack_ff)
      else $error("colon reply did not complete the command");
   a_req_holds: assert property (
      link_tx_req && !tx_ack_s |=> link_tx_req && $stable(link_tx_data))
      else $error("link byte withdrawn before acknowledge");

   c_halt_frame: cover property (
      state_ff == BCD_SEND && cmd == `BCD_CMD_HALT && coord == `BCD_COORD_ON ##1 in_wait);
   c_move_rel: cover property (
      state_ff == BCD_SEND && cmd == `BCD_CMD_MOVE_REL && width == `BCD_W_2 ##1 in_wait);
   c_nak_seen: cover property (in_wait && rx_take && rx_data_s == `BCD_CH_NAK);
   c_two_values: cover property (in_wait && slot_ff == 4'h2 && line_ff);
endmodule

// [rtl/bcd_defs.svh]
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH
// ----------------------------------------
// register offsets (byte address, low 8 bits)
// ----------------------------------------
`define BCD_OFF_CTRL 8'h00
`define BCD_OFF_HDR 8'h04
`define BCD_OFF_STAT 8'h08
`define BCD_OFF_LAST 8'h0c
`define BCD_OFF_FIELD 8'h40
`define BCD_OFF_FIELD_END 8'h7c
`define BCD_OFF_VAL 8'h80
`define BCD_OFF_VAL_END 8'h9c
// ----------------------------------------
// field positions
// ----------------------------------------
`define BCD_CTRL_GO 0
`define BCD_STAT_BUSY 0
`define BCD_STAT_DONE 1
`define BCD_STAT_ACK 2
`define BCD_STAT_NAK 3
`define BCD_STAT_LREJ 4
`define BCD_STAT_OPER 5
`define BCD_STAT_LINE 6
`define BCD_STAT_ERR_LSB 8
`define BCD_STAT_CNT_LSB 16
// ----------------------------------------
// reset values
// ----------------------------------------
`define BCD_HDR_RST 32'h0000_0000
`define BCD_FIELD_RST 48'h0000_0000_0000
// ----------------------------------------
// frame constants
// ----------------------------------------
`define BCD_HDR_LEN 6'h04
`define BCD_CMD_MIN 8'h80
`define BCD_CMD_MOVE_REL 8'ha7
`define BCD_CMD_HALT 8'ha1
`define BCD_W_NONE 8'h00
`define BCD_W_1 8'h01
`define BCD_W_2 8'h02
`define BCD_W_4 8'h04
`define BCD_W_6 8'h06
`define BCD_COORD_OFF 8'h00
`define BCD_COORD_ON 8'h01
`define BCD_NO_FIELD 4'h8
// ----------------------------------------
// reply characters and local error codes
// ----------------------------------------
`define BCD_CH_ACK 8'h3a
`define BCD_CH_NAK 8'h3f
`define BCD_CH_CR 8'h0d
`define BCD_CH_LF 8'h0a
`define BCD_CH_COMMA 8'h2c
`define BCD_CH_SEMI 8'h3b
`define BCD_CH_MINUS 8'h2d
`define BCD_CH_DOT 8'h2e
`define BCD_CH_UNDER 8'h5f
`define BCD_CH_ZERO 8'h30
`define BCD_CH_NINE 8'h39
`define BCD_ERR_NONE 8'h00
`define BCD_ERR_UNRECOG 8'h01
`define BCD_ERR_RANGE 8'h02
`endif

// [rtl/bcd_pkg.sv]
package bcd_pkg;
   // ----------------------------------------
   // frame sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      BCD_IDLE,
      BCD_CHECK,
      BCD_SEND,
      BCD_WAIT
   } bcd_state_t;
endpackage

// [rtl/bcd_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser for pins coming from the device
module bcd_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule

// [sim/bcd_dev_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// device side: takes frames, answers with reply text
// ----------------------------------------
module bcd_dev_model (
   input wire logic hclk,
   input wire logic [7:0] link_tx_data,
   input wire logic link_tx_req,
   output logic link_tx_ack,
   output logic [7:0] link_rx_data,
   output logic link_rx_req,
   input wire logic link_rx_ack
);
   logic [7:0] frm [0:15];
   logic [7:0] txt [0:9] = '{8'h5f, 8'h31, 8'h32, 8'h2c, 8'h2d, 8'h35,
      8'h3b, 8'h0d, 8'h0a, 8'h3a};
   int n = 0;
   int need = 4;
   int len = 0;
   int frames = 0;
   initial begin
      link_tx_ack = 1'b0;
      link_rx_req = 1'b0;
      link_rx_data = 8'h00;
   end
   // data is inverted once released so a late sample cannot pass
   task automatic tx(input logic [7:0] b);
      @(posedge hclk);
      link_rx_data <= b;
      link_rx_req <= 1'b1;
      while (!link_rx_ack) @(posedge hclk);
      link_rx_req <= 1'b0;
      link_rx_data <= ~b;
      while (link_rx_ack) @(posedge hclk);
   endtask
   always begin
      @(posedge hclk);
      if (link_tx_req && !link_tx_ack) begin
         frm[n] = link_tx_data;
         n++;
         link_tx_ack <= 1'b1;
         if (n == 4) need = 4 + $countones(frm[3]) * int'(frm[1]);
      end else if (!link_tx_req && link_tx_ack) begin
         link_tx_ack <= 1'b0;
         if (n == need) begin
            len = n;
            n = 0;
            frames++;
            if (frm[0] == 8'hd9) begin
               foreach (txt[i]) tx(txt[i]);
            end else begin
               // only relative move and halt are taken; others refused
               tx((frm[0] == 8'ha7 || frm[0] == 8'ha1) ? 8'h3a : 8'h3f);
            end
         end
      end
   end
endmodule

// [sim/test_binary_command_decoder.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_binary_command_decoder;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, link_tx_req, link_tx_ack, link_rx_req, link_rx_ack;
   logic [7:0] link_tx_data, link_rx_data;
   int miscompares = 0, check_count = 0, cyc = 0, f;
   logic [7:0] bad [0:4] = '{8'h80, 8'h9b, 8'hef, 8'hff, 8'h7f};
   always #4 hclk = ~hclk;
   bcd_host u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_tx_data(link_tx_data),
      .link_tx_req(link_tx_req), .link_tx_ack(link_tx_ack), .link_rx_data(link_rx_data),
      .link_rx_req(link_rx_req), .link_rx_ack(link_rx_ack));
   bcd_dev_model u_dev (.hclk(hclk), .link_tx_data(link_tx_data),
      .link_tx_req(link_tx_req), .link_tx_ack(link_tx_ack), .link_rx_data(link_rx_data),
      .link_rx_req(link_rx_req), .link_rx_ack(link_rx_ack));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      s = hrdata;
      `CHK(hresp, 1'b0)
   endtask
   task automatic run(input logic [31:0] h);
      xfer(1'b1, 8'h04, h);
      xfer(1'b1, 8'h00, 32'h1);
      s = 32'h0;
      while (s[1] !== 1'b1) xfer(1'b0, 8'h08, 32'h0);
   endtask
   task automatic chkf(input logic [7:0] q [$]);
      foreach (q[i]) `CHK(u_dev.frm[i], q[i])
      `CHK(u_dev.len, q.size())
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_halt;
      run(32'h0701_00a1);
      `CHK(s, 32'h0000_0006)
      chkf({8'ha1, 8'h00, 8'h01, 8'h07});
      xfer(1'b0, 8'h0c, 32'h0);
      `CHK(s, 32'h0000_003a)
      run(32'h0000_02a1);
      chkf({8'ha1, 8'h02, 8'h00, 8'h00});
   endtask
   task automatic t_move;
      xfer(1'b1, 8'h40, 32'h0000_03e8);
      xfer(1'b1, 8'h50, 32'hffff_fe0c);
      xfer(1'b1, 8'h04, 32'h0500_02a7);
      xfer(1'b1, 8'h00, 32'h1);
      xfer(1'b1, 8'h04, 32'h0000_00a1);
      xfer(1'b0, 8'h08, 32'h0);
      `CHK(s[0], 1'b1)
      while (s[1] !== 1'b1) xfer(1'b0, 8'h08, 32'h0);
      chkf({8'ha7, 8'h02, 8'h00, 8'h05, 8'h03, 8'he8, 8'hfe, 8'h0c});
      xfer(1'b0, 8'h04, 32'h0);
      `CHK(s, 32'h0500_02a7)
   endtask
   task automatic t_wide;
      xfer(1'b1, 8'h78, 32'h89ab_cdef);
      xfer(1'b1, 8'h7c, 32'h0000_0123);
      run(32'h8000_06a7);
      chkf({8'ha7, 8'h06, 8'h00, 8'h80, 8'h01, 8'h23, 8'h89, 8'hab, 8'hcd, 8'hef});
      // fields 0 and 2 still hold the values of the move scenario
      run(32'h8400_04a7);
      chkf({8'ha7, 8'h04, 8'h00, 8'h84, 8'hff, 8'hff, 8'hfe, 8'h0c, 8'h89, 8'hab, 8'hcd,
            8'hef});
      run(32'h8100_01a7);
      chkf({8'ha7, 8'h01, 8'h00, 8'h81, 8'he8, 8'hef});
   endtask
   task automatic t_reject;
      f = u_dev.frames;
      foreach (bad[i]) begin
         run({24'h0100_00, bad[i]});
         `CHK(s, 32'h0000_011a)
      end
      run(32'h0100_03a7);
      `CHK(s, 32'h0000_021a)
      run(32'h0102_00a7);
      `CHK(s, 32'h0000_021a)
      `CHK(u_dev.frames, f)
      run(32'h0100_0081);
      `CHK(s, 32'h0000_000a)
   endtask
   task automatic t_query;
      run(32'h0300_00d9);
      `CHK(s, 32'h0002_0066)
      xfer(1'b0, 8'h80, 32'h0);
      `CHK(s, 32'h0000_000c)
      xfer(1'b0, 8'h84, 32'h0);
      `CHK(s, 32'hffff_fffb)
   endtask
   task end_of_test;
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // frames take tens of cycles; the ceiling leaves wide margin
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test;
      end
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, 8'h08, 32'h0);
      `CHK(s, 32'h0)
      t_halt();
      t_move();
      t_wide();
      t_reject();
      t_query();
      end_of_test;
   end
endmodule
